// ---- include/omc_pkg.sv ----
package omc_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned RESET_DELAY_US   = 10;
  localparam int unsigned RESET_DELAY_CYC  = RESET_DELAY_US * CLK_MHZ;
  localparam int unsigned STRAP_FILT_NS    = 2000;
  localparam int unsigned STRAP_FILT_CYC   = (STRAP_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W            = 16;

  // link frame layout
  localparam int unsigned FRAME_W          = 32;
  localparam int unsigned BITCNT_W         = 6;
  localparam logic [31:0] CRC_ON_FRAME     = 32'h67aaaa0e;
  localparam logic [31:0] CRC_OFF_FRAME    = 32'he7aaaac3;

  // reset values
  localparam logic        STRAP_FILT_RST   = 1'h1;
  localparam logic        CRC_EN_RST       = 1'h0;

  typedef enum logic [2:0] {
    OMC_INIT     = 3'h0,
    OMC_NORMAL   = 3'h1,
    OMC_STOP     = 3'h2,
    OMC_SLEEP    = 3'h3,
    OMC_RESTART  = 3'h4,
    OMC_FAILSAFE = 3'h5
  } omc_mode_t;

  // software settings for the switched functions
  typedef struct packed {
    logic       wd_on;
    logic       hs_on;
    logic       bd_on;
    logic       cp_on;
    logic       csa_on;
    logic       can_on;
    logic       cyc_sense_on;
    logic [1:0] cyc_sense_src;
    logic       cyc_wake_on;
    logic       cyc_wake_src;
  } omc_cfg_t;

  // function enables driven to the chip
  typedef struct packed {
    logic       main_regulator_on;
    logic       main_regulator_lp;
    logic       wd_on;
    logic       wd_long_window;
    logic       hs_on;
    logic       bd_on;
    logic       bd_low_side_on;
    logic       cp_on;
    logic       csa_on;
    logic       can_on;
    logic       cyc_sense_on;
    logic [1:0] cyc_sense_src;
    logic       cyc_wake_on;
    logic       cyc_wake_src;
  } omc_func_t;

  // stop-mode interrupt sources
  typedef struct packed {
    logic can_wake;
    logic wake_input;
    logic ls_short;
    logic ov_brake;
  } omc_irq_t;

endpackage

// ---- design/omc_link_rx.sv ----
`timescale 1ns/1ps
module omc_link_rx
  import omc_pkg::*;
(
  input  wire logic                 link_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 cs_n_in,
  input  wire logic                 mosi_in,
  output logic [FRAME_W-1:0]        frame_out,
  output logic                      frame_tgl_out
);
  logic [FRAME_W-1:0]  shift_r;
  logic [FRAME_W-1:0]  shift_nxt;
  logic [BITCNT_W-1:0] bit_cnt_r;
  logic [BITCNT_W-1:0] bit_cnt_nxt;
  logic [FRAME_W-1:0]  frame_r;
  logic [FRAME_W-1:0]  frame_nxt;
  logic                tgl_r;
  logic                tgl_nxt;

  always_comb
  begin
    shift_nxt   = {shift_r[FRAME_W-2:0], mosi_in};
    bit_cnt_nxt = bit_cnt_r + 6'h01;
    frame_nxt   = frame_r;
    tgl_nxt     = tgl_r;
    if (bit_cnt_r == 6'h1f)
    begin
      frame_nxt = shift_nxt;
      tgl_nxt   = ~tgl_r;
    end
  end

  // chip select high ends the frame, no trailing edge needed
  always_ff @(posedge link_clk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      shift_r   <= '0;
      bit_cnt_r <= '0;
    end
    else
    begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  always_ff @(posedge link_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      frame_r <= '0;
      tgl_r   <= 1'h0;
    end
    else if (!cs_n_in)
    begin
      frame_r <= frame_nxt;
      tgl_r   <= tgl_nxt;
    end
  end

  assign frame_out     = frame_r;
  assign frame_tgl_out = tgl_r;
endmodule

// ---- design/omc_top.sv ----
`timescale 1ns/1ps
module omc_top
  import omc_pkg::*;
(
  input  wire logic          clock_in,
  input  wire logic          rst_n_in,
  input  wire logic          link_clk_in,
  input  wire logic          link_cs_n_in,
  input  wire logic          link_mosi_in,
  input  wire logic          checksum_strap_pin_in,
  input  wire logic          main_regulator_ok_in,
  input  wire logic          por_flag_in,
  input  wire logic          sw_dev_latched_in,
  input  wire logic          req_normal_in,
  input  wire logic          req_stop_in,
  input  wire logic          req_sleep_in,
  input  wire logic          soft_reset_in,
  input  wire logic          wd_fail_in,
  input  wire logic          fail_safe_in,
  input  wire logic          wake_in,
  input  wire logic          spi_write_in,
  input  wire logic          spi_write_exempt_in,
  input  wire logic          spi_fail_clr_in,
  input  wire logic          brake_req_in,
  input  omc_pkg::omc_cfg_t  cfg_in,
  input  omc_pkg::omc_irq_t  irq_evt_in,
  input  omc_pkg::omc_irq_t  irq_mask_in,
  output omc_pkg::omc_mode_t mode_out,
  output omc_pkg::omc_func_t func_out,
  output logic               mcu_reset_output_n_out,
  output logic               wd_start_out,
  output logic               crc_en_out,
  output logic               spi_write_accept_out,
  output logic               spi_fail_out,
  output logic               irq_out,
  output logic [31:0]        frame_out,
  output logic               frame_valid_out
);
  import omc_pkg::*;

  // pin and link crossings
  logic [2:0]  pin_raw;
  logic [2:0]  pin_s1_r;
  logic [2:0]  pin_s2_r;
  logic [31:0] link_frame;
  logic        link_tgl;
  logic [2:0]  tgl_sync_r;

  assign pin_raw = {checksum_strap_pin_in, main_regulator_ok_in, por_flag_in};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_pin_sync
      always_ff @(posedge clock_in or negedge rst_n_in)
      begin
        if (!rst_n_in)
        begin
          pin_s1_r[gi] <= 1'h0;
          pin_s2_r[gi] <= 1'h0;
        end
        else
        begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  logic strap_s;
  logic reg_ok_s;
  logic por_s;
  assign strap_s  = pin_s2_r[2];
  assign reg_ok_s = pin_s2_r[1];
  assign por_s    = pin_s2_r[0];

  omc_link_rx u_link_rx (
    .link_clk_in   (link_clk_in),
    .rst_n_in      (rst_n_in),
    .cs_n_in       (link_cs_n_in),
    .mosi_in       (link_mosi_in),
    .frame_out     (link_frame),
    .frame_tgl_out (link_tgl)
  );

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tgl_sync_r <= '0;
    else
      tgl_sync_r <= {tgl_sync_r[1:0], link_tgl};
  end

  logic frame_new;
  assign frame_new = tgl_sync_r[2] ^ tgl_sync_r[1];

  // mode machine and reset output
  omc_mode_t  mode_r, mode_nxt;
  logic       rst_out_r, rst_out_nxt;
  logic [CNT_W-1:0] dly_r, dly_nxt;
  logic       from_por_r, from_por_nxt;
  logic       wd_fail_restart;
  logic       dly_done;

  assign dly_done        = (dly_r == CNT_W'(RESET_DELAY_CYC - 1));
  assign wd_fail_restart = wd_fail_in && !sw_dev_latched_in;

  always_comb
  begin
    mode_nxt     = mode_r;
    rst_out_nxt  = rst_out_r;
    dly_nxt      = dly_r;
    from_por_nxt = from_por_r;
    case (mode_r)
      OMC_INIT:
      begin
        if (!rst_out_r)
        begin
          dly_nxt = dly_done ? dly_r : dly_r + 16'h0001;
          rst_out_nxt = dly_done;
        end
        else if (req_normal_in)
          mode_nxt = OMC_NORMAL;
      end
      OMC_NORMAL:
      begin
        if (req_stop_in)
          mode_nxt = OMC_STOP;
        else if (req_sleep_in)
          mode_nxt = OMC_SLEEP;
      end
      OMC_STOP:
      begin
        if (req_normal_in)
          mode_nxt = OMC_NORMAL;
      end
      OMC_SLEEP:
      begin
        if (wake_in)
          mode_nxt = OMC_RESTART;
      end
      OMC_RESTART:
      begin
        rst_out_nxt = 1'h0;
        dly_nxt = dly_r + 16'h0001;
        if (dly_done)
        begin
          mode_nxt    = OMC_NORMAL;
          rst_out_nxt = 1'h1;
        end
      end
      OMC_FAILSAFE:
      begin
        if (wake_in)
          mode_nxt = OMC_RESTART;
      end
      default:
        mode_nxt = OMC_INIT;
    endcase
    if (mode_r != OMC_RESTART && mode_nxt == OMC_RESTART)
      dly_nxt = '0;
    if (fail_safe_in)
    begin
      mode_nxt    = OMC_FAILSAFE;
      rst_out_nxt = 1'h0;
    end
    else if (soft_reset_in && (mode_r == OMC_NORMAL || mode_r == OMC_STOP))
    begin
      mode_nxt     = OMC_INIT;
      from_por_nxt = 1'h0;
    end
    else if (rst_out_r && (wd_fail_restart || !reg_ok_s) && mode_r != OMC_SLEEP)
    begin
      mode_nxt    = OMC_RESTART;
      rst_out_nxt = 1'h0;
      dly_nxt     = '0;
    end
    if (mode_nxt == OMC_SLEEP)
      rst_out_nxt = 1'h0;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mode_r     <= OMC_INIT;
      rst_out_r  <= 1'h0;
      dly_r      <= '0;
      from_por_r <= 1'h1;
    end
    else
    begin
      mode_r     <= mode_nxt;
      rst_out_r  <= rst_out_nxt;
      dly_r      <= dly_nxt;
      from_por_r <= from_por_nxt;
    end
  end

  // checksum strap filter and latch
  logic strap_filt_r, strap_filt_nxt;
  logic [CNT_W-1:0] filt_cnt_r, filt_cnt_nxt;
  logic crc_en_r, crc_en_nxt;
  logic eval_ok;
  logic rst_rise;

  assign eval_ok  = ((mode_r == OMC_INIT && from_por_r) || mode_r == OMC_RESTART)
                    && reg_ok_s && por_s && !rst_out_r;
  assign rst_rise = rst_out_nxt && !rst_out_r;

  always_comb
  begin
    strap_filt_nxt = strap_filt_r;
    filt_cnt_nxt   = '0;
    crc_en_nxt     = crc_en_r;
    if (eval_ok && strap_s != strap_filt_r)
    begin
      filt_cnt_nxt = filt_cnt_r + 16'h0001;
      if (filt_cnt_r == CNT_W'(STRAP_FILT_CYC - 1))
      begin
        strap_filt_nxt = strap_s;
        filt_cnt_nxt   = '0;
      end
    end
    if (eval_ok && rst_rise)
      crc_en_nxt = !strap_filt_r;
    else if (frame_new && link_frame == CRC_ON_FRAME)
      crc_en_nxt = 1'h1;
    else if (frame_new && link_frame == CRC_OFF_FRAME)
      crc_en_nxt = 1'h0;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      strap_filt_r <= STRAP_FILT_RST;
      filt_cnt_r   <= '0;
      crc_en_r     <= CRC_EN_RST;
    end
    else
    begin
      strap_filt_r <= strap_filt_nxt;
      filt_cnt_r   <= filt_cnt_nxt;
      crc_en_r     <= crc_en_nxt;
    end
  end

  // held settings and function enables
  omc_cfg_t  held_r, held_nxt;
  omc_func_t func_r, func_nxt;

  always_comb
  begin
    held_nxt = held_r;
    if (mode_r == OMC_NORMAL)
      held_nxt = cfg_in;
    func_nxt = '0;
    case (mode_r)
      OMC_INIT:
      begin
        func_nxt.main_regulator_on = 1'h1;
        func_nxt.wd_on             = rst_out_r;
        func_nxt.wd_long_window    = 1'h1;
        func_nxt.can_on            = sw_dev_latched_in;
      end
      OMC_NORMAL:
      begin
        func_nxt.main_regulator_on = 1'h1;
        func_nxt.wd_on             = cfg_in.wd_on;
        func_nxt.hs_on             = cfg_in.hs_on;
        func_nxt.bd_on             = cfg_in.bd_on;
        func_nxt.bd_low_side_on    = cfg_in.bd_on;
        func_nxt.cp_on             = cfg_in.cp_on;
        func_nxt.csa_on            = cfg_in.csa_on;
        func_nxt.can_on            = cfg_in.can_on;
        func_nxt.cyc_sense_on      = cfg_in.cyc_sense_on;
        func_nxt.cyc_sense_src     = cfg_in.cyc_sense_src;
        func_nxt.cyc_wake_on       = cfg_in.cyc_wake_on;
        func_nxt.cyc_wake_src      = cfg_in.cyc_wake_src;
      end
      OMC_STOP:
      begin
        func_nxt.main_regulator_on = 1'h1;
        func_nxt.main_regulator_lp = 1'h1;
        func_nxt.wd_on             = held_r.wd_on;
        func_nxt.hs_on             = held_r.hs_on;
        func_nxt.can_on            = held_r.can_on;
        func_nxt.cyc_sense_on      = held_r.cyc_sense_on;
        func_nxt.cyc_sense_src     = held_r.cyc_sense_src;
        func_nxt.cyc_wake_on       = held_r.cyc_wake_on;
        func_nxt.cyc_wake_src      = held_r.cyc_wake_src;
        func_nxt.bd_low_side_on    = brake_req_in;
      end
      OMC_SLEEP:
      begin
        func_nxt.hs_on             = held_r.hs_on;
        func_nxt.can_on            = held_r.can_on;
        func_nxt.cyc_sense_on      = held_r.cyc_sense_on;
        func_nxt.cyc_sense_src     = held_r.cyc_sense_src;
        func_nxt.cyc_wake_on       = held_r.cyc_wake_on;
        func_nxt.cyc_wake_src      = held_r.cyc_wake_src;
        func_nxt.bd_low_side_on    = brake_req_in;
      end
      OMC_RESTART:
        func_nxt.main_regulator_on = 1'h1;
      OMC_FAILSAFE:
        func_nxt.can_on            = 1'h1;
      default:
        func_nxt = '0;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      held_r <= '0;
      func_r <= '0;
    end
    else
    begin
      held_r <= held_nxt;
      func_r <= func_nxt;
    end
  end

  // write filter, interrupt, watchdog start, frame out
  logic        fail_r, fail_nxt;
  logic        acc_r, acc_nxt;
  logic        irq_r, irq_nxt;
  logic        wds_r, wds_nxt;
  logic [31:0] frm_r, frm_nxt;
  logic        frv_r, frv_nxt;
  logic        write_blocked;

  assign write_blocked = spi_write_in && mode_r == OMC_STOP && !spi_write_exempt_in;

  always_comb
  begin
    acc_nxt  = spi_write_in && !write_blocked;
    fail_nxt = write_blocked ? 1'h1 : (spi_fail_clr_in ? 1'h0 : fail_r);
    irq_nxt  = |(irq_evt_in & irq_mask_in);
    wds_nxt  = rst_rise && mode_r == OMC_INIT;
    frm_nxt  = frame_new ? link_frame : frm_r;
    frv_nxt  = frame_new;
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      fail_r <= 1'h0;
      acc_r  <= 1'h0;
      irq_r  <= 1'h0;
      wds_r  <= 1'h0;
      frm_r  <= '0;
      frv_r  <= 1'h0;
    end
    else
    begin
      fail_r <= fail_nxt;
      acc_r  <= acc_nxt;
      irq_r  <= irq_nxt;
      wds_r  <= wds_nxt;
      frm_r  <= frm_nxt;
      frv_r  <= frv_nxt;
    end
  end

  assign mode_out               = mode_r;
  assign func_out               = func_r;
  assign mcu_reset_output_n_out = rst_out_r;
  assign wd_start_out           = wds_r;
  assign crc_en_out             = crc_en_r;
  assign spi_write_accept_out   = acc_r;
  assign spi_fail_out           = fail_r;
  assign irq_out                = irq_r;
  assign frame_out              = frm_r;
  assign frame_valid_out        = frv_r;

  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);

  a_crc_on_frame: assert property (
    frame_new && link_frame == CRC_ON_FRAME && !(eval_ok && rst_rise) |=> crc_en_r)
    else $error("checksum not enabled by frame");
  a_crc_off_frame: assert property (
    frame_new && link_frame == CRC_OFF_FRAME && !(eval_ok && rst_rise) |=> !crc_en_r)
    else $error("checksum not disabled by frame");
  a_crc_latch_edge: assert property (
    eval_ok && rst_rise |=> crc_en_r == !$past(strap_filt_r))
    else $error("strap not latched at reset release");
  a_crc_hold_val: assert property (
    !frame_new && !rst_rise |=> $stable(crc_en_r))
    else $error("checksum setting changed unexpectedly");
  a_filt_no_eval: assert property (
    !eval_ok |=> $stable(strap_filt_r))
    else $error("strap filter moved outside evaluation");
  a_filt_stable: assert property (
    strap_s != strap_filt_r && eval_ok ##1 $changed(strap_filt_r)
    |-> $past(filt_cnt_r) == CNT_W'(STRAP_FILT_CYC - 1))
    else $error("filter time wrong");
  a_stop_write_drop: assert property (
    write_blocked |=> !acc_r && fail_r)
    else $error("stop write not dropped");
  a_fail_set_wins: assert property (
    write_blocked && spi_fail_clr_in |=> fail_r)
    else $error("clear beat error set");
  a_restart_rst_low: assert property (
    mode_r == OMC_RESTART |-> !rst_out_r)
    else $error("reset output high in restart");
  a_init_funcs: assert property (
    mode_r == OMC_INIT ##1 mode_r == OMC_INIT
    |-> func_r.main_regulator_on && func_r.wd_long_window && !func_r.bd_on && !func_r.hs_on)
    else $error("init functions wrong");
  a_stop_funcs: assert property (
    mode_r == OMC_STOP ##1 mode_r == OMC_STOP |-> func_r.main_regulator_lp && !func_r.bd_on
    && !func_r.cp_on && !func_r.csa_on && func_r.hs_on == held_r.hs_on)
    else $error("stop functions wrong");
  a_sleep_funcs: assert property (
    mode_r == OMC_SLEEP ##1 mode_r == OMC_SLEEP
    |-> !func_r.main_regulator_on && !func_r.wd_on && !func_r.cp_on)
    else $error("sleep funcs");
  a_swdev_no_wd: assert property (
    sw_dev_latched_in && wd_fail_in && reg_ok_s && !fail_safe_in
    && mode_r == OMC_NORMAL && !soft_reset_in |=> mode_r != OMC_RESTART)
    else $error("watchdog restart in development setting");
  a_stop_irq_mode: assert property (
    mode_r == OMC_STOP && |(irq_evt_in & irq_mask_in)
    && !req_normal_in && !fail_safe_in && !soft_reset_in && !wd_fail_restart && reg_ok_s
    |=> irq_r && mode_r == OMC_STOP) else $error("stop interrupt wrong");

  c_crc_recover: cover property (frame_new && link_frame == CRC_ON_FRAME);
  c_init_release: cover property (mode_r == OMC_INIT && rst_rise);
  c_stop_drop: cover property (write_blocked);
  c_sleep_wake: cover property (mode_r == OMC_SLEEP ##1 mode_r == OMC_RESTART);
endmodule

// ---- sim/omc_mcu_model.sv ----
`timescale 1ns/1ps
module omc_mcu_model
(
  output logic link_clk_out,
  output logic cs_n_out,
  output logic mosi_out
);
  initial
  begin
    link_clk_out = 1'h0;
    cs_n_out     = 1'h1;
    mosi_out     = 1'h0;
  end

  // one frame, msb first; clock stands low between frames
  // caller sends recovery words in normal mode only
  task automatic send(input logic [31:0] w, input int slow);
    #1.3;
    cs_n_out = 1'h0;
    for (int i = 31; i >= 0; i--)
    begin
      mosi_out = w[i];
      #(3 + slow);
      link_clk_out = 1'h1;
      #(3 + slow);
      link_clk_out = 1'h0;
    end
    #3;
    cs_n_out = 1'h1;
    mosi_out = ~w[0];
  endtask
endmodule

// ---- sim/operating_mode_control_tb.sv ----
`timescale 1ns/1ps
module operating_mode_control_tb;
  import omc_pkg::*;
  localparam omc_cfg_t CFG_ON = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 2'h2, 1'h1, 1'h1};
  logic        clock_in, rst_n_in, strap, sw_dev, wake, wr, wr_ex, fclr, brake, por, wd_fail;
  logic [2:0]  reqs;
  omc_cfg_t    cfg;
  omc_irq_t    evt, msk;
  omc_mode_t   mode;
  omc_func_t   func;
  logic        rst_out_n, wd_start, crc_en, acc, sfail, irq, fvalid;
  logic [31:0] frame;
  wire         link_clk, cs_n, mosi;
  int          fails, tests_run, wd_cnt, fv_cnt;

  omc_mcu_model mcu (.link_clk_out(link_clk), .cs_n_out(cs_n), .mosi_out(mosi));

  omc_top uut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .link_clk_in(link_clk),
    .link_cs_n_in(cs_n), .link_mosi_in(mosi), .checksum_strap_pin_in(strap),
    .main_regulator_ok_in(1'h1), .por_flag_in(por), .sw_dev_latched_in(sw_dev),
    .req_normal_in(reqs[2]), .req_stop_in(reqs[1]), .req_sleep_in(reqs[0]),
    .soft_reset_in(1'h0), .wd_fail_in(wd_fail), .fail_safe_in(1'h0), .wake_in(wake),
    .spi_write_in(wr), .spi_write_exempt_in(wr_ex), .spi_fail_clr_in(fclr),
    .brake_req_in(brake), .cfg_in(cfg), .irq_evt_in(evt), .irq_mask_in(msk),
    .mode_out(mode), .func_out(func), .mcu_reset_output_n_out(rst_out_n),
    .wd_start_out(wd_start), .crc_en_out(crc_en), .spi_write_accept_out(acc),
    .spi_fail_out(sfail), .irq_out(irq), .frame_out(frame), .frame_valid_out(fvalid)
  );

  initial
  begin
    clock_in = 1'h0;
    forever #4 clock_in = ~clock_in;
  end

  always @(posedge clock_in)
  begin
    if (wd_start === 1'h1) wd_cnt++;
    if (fvalid === 1'h1) fv_cnt++;
  end

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic mchk(input omc_mode_t m);
    chk({29'h0, mode}, {29'h0, m});
  endtask

  // masked compare of the function enables
  task automatic fchk(input logic [14:0] e, input logic [14:0] m);
    chk({17'h0, func & m}, {17'h0, e});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic req(input logic [2:0] r);
    @(posedge clock_in);
    reqs <= r;
    @(posedge clock_in);
    reqs <= 3'h0;
    cyc(3);
  endtask

  task automatic wait_rst;
    for (int i = 0; i < 2000 && rst_out_n !== 1'h1; i++) cyc(1);
    cyc(2);
  endtask

  task automatic frm(input logic [31:0] w, input int slow, input logic exp);
    mcu.send(w, slow);
    cyc(10);
    chk(frame, w);
    chk({31'h0, crc_en}, {31'h0, exp});
  endtask

  task automatic wrt(input logic ex, input logic e_acc, input logic e_fail);
    @(posedge clock_in);
    wr <= 1'h1;
    wr_ex <= ex;
    @(posedge clock_in);
    wr <= 1'h0;
    #1;
    chk({30'h0, acc, sfail}, {30'h0, e_acc, e_fail});
  endtask

  initial
  begin
    #200000;
    fails++;
    final_report();
  end

  initial
  begin
    rst_n_in = 1'h0;
    strap = 1'h0;
    sw_dev = 1'h0;
    wake = 1'h0;
    wr = 1'h0;
    wr_ex = 1'h0;
    fclr = 1'h0;
    brake = 1'h0;
    reqs = 3'h0;
    cfg = CFG_ON;
    evt = 4'h0;
    msk = 4'h0;
    por = 1'h1;
    wd_fail = 1'h0;
    cyc(11);
    mchk(OMC_INIT);
    chk({31'h0, rst_out_n}, 32'h0);
    @(posedge clock_in);
    rst_n_in <= 1'h1;
    // strap pulled low through the delay
    wait_rst();
    chk({31'h0, crc_en}, 32'h1);
    chk(wd_cnt, 32'h1);
    fchk(15'h5000, 15'h76ff);
    chk({31'h0, func.wd_long_window}, 32'h1);
    @(posedge clock_in);
    sw_dev <= 1'h1;
    cyc(3);
    fchk(15'h5020, 15'h76ff);
    @(posedge clock_in);
    sw_dev <= 1'h0;
    req(3'h4);
    mchk(OMC_NORMAL);
    fchk(15'h56fb, 15'h76ff);
    // recovery words, then a plain word
    frm(CRC_OFF_FRAME, 0, 1'h0);
    frm(CRC_ON_FRAME, 4, 1'h1);
    frm(32'h12345678, 0, 1'h1);
    chk(fv_cnt, 32'h3);
    @(posedge clock_in);
    strap <= 1'h1;
    cyc(300);
    chk({31'h0, crc_en}, 32'h1);
    // watchdog failure ignored in development setting
    @(posedge clock_in);
    sw_dev <= 1'h1;
    wd_fail <= 1'h1;
    cyc(3);
    mchk(OMC_NORMAL);
    @(posedge clock_in);
    sw_dev <= 1'h0;
    wd_fail <= 1'h0;
    // settings done before stop
    req(3'h2);
    mchk(OMC_STOP);
    fchk(15'h743b, 15'h76ff);
    @(posedge clock_in);
    cfg <= '0;
    cyc(3);
    fchk(15'h743b, 15'h76ff);
    wrt(1'h0, 1'h0, 1'h1);
    wrt(1'h1, 1'h1, 1'h1);
    @(posedge clock_in);
    fclr <= 1'h1;
    @(posedge clock_in);
    fclr <= 1'h0;
    cyc(2);
    chk({31'h0, sfail}, 32'h0);
    @(posedge clock_in);
    brake <= 1'h1;
    cyc(3);
    chk({31'h0, func.bd_low_side_on}, 32'h1);
    @(posedge clock_in);
    brake <= 1'h0;
    msk <= 4'h2;
    evt <= 4'h1;
    cyc(3);
    chk({31'h0, irq}, 32'h0);
    @(posedge clock_in);
    evt <= 4'h2;
    cyc(3);
    chk({31'h0, irq}, 32'h1);
    mchk(OMC_STOP);
    @(posedge clock_in);
    evt <= 4'h0;
    cfg <= CFG_ON;
    req(3'h4);
    req(3'h1);
    mchk(OMC_SLEEP);
    fchk(15'h043b, 15'h56ff);
    @(posedge clock_in);
    wake <= 1'h1;
    @(posedge clock_in);
    wake <= 1'h0;
    cyc(3);
    mchk(OMC_RESTART);
    chk({31'h0, rst_out_n}, 32'h0);
    // strap now open, so restart clears the setting
    wait_rst();
    chk({31'h0, crc_en}, 32'h0);
    mchk(OMC_NORMAL);
    frm(CRC_ON_FRAME, 0, 1'h1);
    // power-on flag low, so the watchdog restart keeps the setting
    @(posedge clock_in);
    por <= 1'h0;
    wd_fail <= 1'h1;
    @(posedge clock_in);
    wd_fail <= 1'h0;
    cyc(3);
    mchk(OMC_RESTART);
    chk({31'h0, rst_out_n}, 32'h0);
    wait_rst();
    chk({31'h0, crc_en}, 32'h1);
    mchk(OMC_NORMAL);
    final_report();
  end
endmodule
